// ### src/bacp_pkg.sv
// constants shared by the buffer address and color packer
package bacp_pkg;
    localparam int unsigned COORD_W = 12;
    localparam int unsigned ADDR_W = 24;
    localparam int unsigned BYTE_ADDR_W = 26;
    localparam int unsigned PP_W = 3;
    localparam int unsigned WIDTH_W = 12;

    // apb register byte offsets
    localparam logic [7:0] REG_DEPTH_READ_CONTROL = 8'h00;
    localparam logic [7:0] REG_DEPTH_WINDOW_BASE = 8'h04;
    localparam logic [7:0] REG_DEPTH_COPY_OFFSET = 8'h08;
    localparam logic [7:0] REG_DEPTH_LAYOUT = 8'h0c;
    localparam logic [7:0] REG_COLOR_READ_CONTROL = 8'h10;
    localparam logic [7:0] REG_COLOR_WINDOW_BASE = 8'h14;
    localparam logic [7:0] REG_COLOR_COPY_OFFSET = 8'h18;
    localparam logic [7:0] REG_COLOR_PIXEL_SHIFT = 8'h1c;
    localparam logic [7:0] REG_COLOR_FORMAT = 8'h20;
    localparam logic [7:0] REG_STATUS = 8'h24;

    // read control fields (depth and color alike)
    localparam int unsigned RC_TERM_A_LSB = 0;
    localparam int unsigned RC_TERM_B_LSB = 3;
    localparam int unsigned RC_TERM_C_LSB = 6;
    localparam int unsigned RC_ORIGIN_BIT = 9;
    localparam int unsigned RC_PATCH_BIT = 10;
    localparam int unsigned RC_SUBPATCH_BIT = 11;
    // depth layout fields
    localparam int unsigned DL_DEPTH16_BIT = 0;
    localparam int unsigned DL_STENCIL_BIT = 1;
    // color format fields
    localparam int unsigned CF_FMT_LSB = 0;
    localparam int unsigned CF_FMT_W = 5;
    localparam int unsigned CF_ORDER_BIT = 5;
    localparam int unsigned CF_PIX32_BIT = 6;
    localparam int unsigned CF_RAW_BIT = 7;

    localparam logic [31:0] RESET_READ_CONTROL = 32'h0000_0000;
    localparam logic [31:0] RESET_DEPTH_LAYOUT = 32'h0000_0001;
    localparam logic [31:0] RESET_COLOR_FORMAT = 32'h0000_0000;
    localparam logic [7:0] OFFSET_BIAS = 8'h40;
    localparam int unsigned STENCIL_POS = 15;

    // framebuffer format codes
    localparam logic [4:0] FMT_8888 = 5'h00;
    localparam logic [4:0] FMT_5551_F = 5'h01;
    localparam logic [4:0] FMT_4444 = 5'h02;
    localparam logic [4:0] FMT_332_F = 5'h05;
    localparam logic [4:0] FMT_332_B = 5'h06;
    localparam logic [4:0] FMT_2321_F = 5'h09;
    localparam logic [4:0] FMT_2321_B = 5'h0a;
    localparam logic [4:0] FMT_232_FO = 5'h0b;
    localparam logic [4:0] FMT_232_BO = 5'h0c;
    localparam logic [4:0] FMT_5551_B = 5'h0d;
    localparam logic [4:0] FMT_CI8 = 5'h0e;
    localparam logic [4:0] FMT_565_F = 5'h10;
    localparam logic [4:0] FMT_565_B = 5'h11;
endpackage : bacp_pkg

// ### src/bacp_addr_gen.sv
// one buffer's pixel and byte address generator, one registered stage
`timescale 1ns/1ps
`default_nettype none
module bacp_addr_gen
(
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire logic valid_i,
    input wire logic [bacp_pkg::COORD_W-1:0] x_i,
    input wire logic [bacp_pkg::COORD_W-1:0] y_i,
    input wire logic [bacp_pkg::PP_W-1:0] term_a_i,
    input wire logic [bacp_pkg::PP_W-1:0] term_b_i,
    input wire logic [bacp_pkg::PP_W-1:0] term_c_i,
    input wire logic origin_select_i,
    input wire logic [bacp_pkg::ADDR_W-1:0] window_base_i,
    input wire logic [bacp_pkg::ADDR_W-1:0] copy_offset_i,
    input wire logic [bacp_pkg::ADDR_W-1:0] pixel_shift_i,
    input wire logic [1:0] bytes_log2_i,
    output logic [bacp_pkg::BYTE_ADDR_W-1:0] dst_addr_o,
    output logic [bacp_pkg::BYTE_ADDR_W-1:0] src_addr_o
);
    import bacp_pkg::*;

    // partial product term: zero selects nothing, k selects 2^(k+3)
    function automatic logic [WIDTH_W-1:0] term(input logic [PP_W-1:0] sel);
        logic [WIDTH_W-1:0] r;
        r = '0;
        if (sel != 3'h0)
        begin
            r = WIDTH_W'(12'h008 << sel);
        end
        return r;
    endfunction : term

    logic [WIDTH_W-1:0] width;
    logic [ADDR_W-1:0] row;
    logic [ADDR_W-1:0] dst_pix;
    logic [ADDR_W-1:0] src_pix;

    assign width = WIDTH_W'(term(term_a_i) + term(term_b_i) + term(term_c_i));
    // widen before the product so high rows keep their upper bits
    assign row = ADDR_W'(y_i) * ADDR_W'(width);

    always_comb
    begin
        if (origin_select_i)
        begin
            dst_pix = ADDR_W'(window_base_i + row + ADDR_W'(x_i) + pixel_shift_i);
        end
        else
        begin
            dst_pix = ADDR_W'(window_base_i - row + ADDR_W'(x_i) + pixel_shift_i);
        end
        src_pix = ADDR_W'(dst_pix + copy_offset_i);
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            dst_addr_o <= '0;
            src_addr_o <= '0;
        end
        else if (valid_i)
        begin
            dst_addr_o <= BYTE_ADDR_W'({2'b00, dst_pix} << bytes_log2_i);
            src_addr_o <= BYTE_ADDR_W'({2'b00, src_pix} << bytes_log2_i);
        end
    end
endmodule : bacp_addr_gen
`default_nettype wire

// ### src/bacp_color_pack.sv
// packs internal 8-bit rgba into the framebuffer word, one registered stage
`timescale 1ns/1ps
`default_nettype none
module bacp_color_pack
(
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire logic valid_i,
    input wire logic [31:0] color_i,
    input wire logic [4:0] format_i,
    input wire logic channel_order_bit_i,
    input wire logic pix32_i,
    input wire logic raw_i,
    output logic [31:0] word_o,
    output logic [3:0] byte_en_o,
    output logic format_bad_o
);
    import bacp_pkg::*;

    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
    logic [7:0] a;
    logic [15:0] h16;
    logic [7:0] v8;
    logic [31:0] packed_w;
    logic bad;

    // order bit swaps red and blue
    assign r = channel_order_bit_i ? color_i[23:16] : color_i[7:0];
    assign b = channel_order_bit_i ? color_i[7:0] : color_i[23:16];
    assign g = color_i[15:8];
    assign a = color_i[31:24];

    always_comb
    begin
        h16 = '0;
        v8 = '0;
        bad = 1'b0;
        packed_w = '0;
        unique case (format_i)
            FMT_8888: packed_w = {a, b, g, r};
            FMT_5551_F, FMT_5551_B: h16 = {a[7], b[7:3], g[7:3], r[7:3]};
            FMT_4444: h16 = {a[7:4], b[7:4], g[7:4], r[7:4]};
            FMT_565_F, FMT_565_B: h16 = {b[7:3], g[7:2], r[7:3]};
            FMT_332_F, FMT_332_B: v8 = {b[7:6], g[7:5], r[7:5]};
            FMT_2321_F, FMT_2321_B: v8 = {a[7], b[7:6], g[7:5], r[7:6]};
            FMT_232_FO, FMT_232_BO: v8 = 8'({1'b0, b[7:6], g[7:5], r[7:6]} + OFFSET_BIAS);
            FMT_CI8: v8 = r;
            default: bad = 1'b1;
        endcase
        if (v8 != 8'h00 || format_i inside {FMT_332_F, FMT_332_B, FMT_2321_F, FMT_2321_B,
                                           FMT_232_FO, FMT_232_BO, FMT_CI8})
        begin
            packed_w = {4{v8}};
        end
        if (format_i inside {FMT_5551_F, FMT_5551_B, FMT_4444, FMT_565_F, FMT_565_B})
        begin
            packed_w = {2{h16}};
        end
        if (raw_i)
        begin
            packed_w = color_i;
            bad = 1'b0;
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            word_o <= '0;
            byte_en_o <= '0;
            format_bad_o <= 1'b0;
        end
        else if (valid_i)
        begin
            word_o <= packed_w;
            byte_en_o <= (pix32_i || raw_i) ? 4'hf : 4'h3;
            format_bad_o <= bad;
        end
    end
endmodule : bacp_color_pack
`default_nettype wire

// ### src/bacp_top.sv
// buffer address and color packer: apb registers, two address units, packer
`timescale 1ns/1ps
`default_nettype none
module bacp_top
(
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic pix_valid_i,
    input wire logic [bacp_pkg::COORD_W-1:0] pix_x_i,
    input wire logic [bacp_pkg::COORD_W-1:0] pix_y_i,
    input wire logic [31:0] pix_color_i,
    input wire logic [15:0] pix_depth_i,
    input wire logic pix_stencil_i,
    output logic out_valid_o,
    output logic [bacp_pkg::BYTE_ADDR_W-1:0] depth_dst_addr_o,
    output logic [bacp_pkg::BYTE_ADDR_W-1:0] depth_src_addr_o,
    output logic [15:0] depth_word_o,
    output logic [bacp_pkg::BYTE_ADDR_W-1:0] color_dst_addr_o,
    output logic [bacp_pkg::BYTE_ADDR_W-1:0] color_src_addr_o,
    output logic [31:0] color_word_o,
    output logic [3:0] color_byte_en_o,
    output logic depth_patched_o,
    output logic color_patched_o,
    output logic color_subpatched_o
);
    import bacp_pkg::*;

    logic [31:0] depth_read_control_q;
    logic [ADDR_W-1:0] depth_window_base_q;
    logic [ADDR_W-1:0] depth_copy_offset_q;
    logic [31:0] depth_layout_q;
    logic [31:0] color_read_control_q;
    logic [ADDR_W-1:0] color_window_base_q;
    logic [ADDR_W-1:0] color_copy_offset_q;
    logic [ADDR_W-1:0] color_pixel_shift_q;
    logic [31:0] color_format_q;
    logic format_bad;
    logic sticky_bad_q;
    logic wr_en;
    logic rd_ok;
    logic [1:0] color_bytes_log2;

    // single-cycle access phase: pready always high
    assign pready_o = 1'b1;
    assign wr_en = psel_i && penable_i && pwrite_i;

    always_comb
    begin
        rd_ok = 1'b1;
        prdata_o = 32'h0;
        unique case (paddr_i)
            REG_DEPTH_READ_CONTROL: prdata_o = depth_read_control_q;
            REG_DEPTH_WINDOW_BASE: prdata_o = {8'h00, depth_window_base_q};
            REG_DEPTH_COPY_OFFSET: prdata_o = {8'h00, depth_copy_offset_q};
            REG_DEPTH_LAYOUT: prdata_o = depth_layout_q;
            REG_COLOR_READ_CONTROL: prdata_o = color_read_control_q;
            REG_COLOR_WINDOW_BASE: prdata_o = {8'h00, color_window_base_q};
            REG_COLOR_COPY_OFFSET: prdata_o = {8'h00, color_copy_offset_q};
            REG_COLOR_PIXEL_SHIFT: prdata_o = {8'h00, color_pixel_shift_q};
            REG_COLOR_FORMAT: prdata_o = color_format_q;
            REG_STATUS: prdata_o = {31'h0, sticky_bad_q};
            default: rd_ok = 1'b0;
        endcase
    end
    // unmapped addresses answer with an error
    assign pslverr_o = psel_i && penable_i && !rd_ok;

    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            depth_read_control_q <= RESET_READ_CONTROL;
            depth_window_base_q <= '0;
            depth_copy_offset_q <= '0;
            depth_layout_q <= RESET_DEPTH_LAYOUT;
            color_read_control_q <= RESET_READ_CONTROL;
            color_window_base_q <= '0;
            color_copy_offset_q <= '0;
            color_pixel_shift_q <= '0;
            color_format_q <= RESET_COLOR_FORMAT;
        end
        else if (wr_en)
        begin
            unique case (paddr_i)
                REG_DEPTH_READ_CONTROL: depth_read_control_q <= {20'h0, pwdata_i[11:0]};
                REG_DEPTH_WINDOW_BASE: depth_window_base_q <= pwdata_i[ADDR_W-1:0];
                REG_DEPTH_COPY_OFFSET: depth_copy_offset_q <= pwdata_i[ADDR_W-1:0];
                REG_DEPTH_LAYOUT: depth_layout_q <= {30'h0, pwdata_i[1:0]};
                REG_COLOR_READ_CONTROL: color_read_control_q <= {20'h0, pwdata_i[11:0]};
                REG_COLOR_WINDOW_BASE: color_window_base_q <= pwdata_i[ADDR_W-1:0];
                REG_COLOR_COPY_OFFSET: color_copy_offset_q <= pwdata_i[ADDR_W-1:0];
                REG_COLOR_PIXEL_SHIFT: color_pixel_shift_q <= pwdata_i[ADDR_W-1:0];
                REG_COLOR_FORMAT: color_format_q <= {24'h0, pwdata_i[7:0]};
                default: ;
            endcase
        end
    end

    // sticky flag: a new bad pixel wins over a software clear
    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            sticky_bad_q <= 1'b0;
        end
        else if (out_valid_o && format_bad)
        begin
            sticky_bad_q <= 1'b1;
        end
        else if (wr_en && paddr_i == REG_STATUS && pwdata_i[0])
        begin
            sticky_bad_q <= 1'b0;
        end
    end

    assign depth_patched_o = depth_read_control_q[RC_PATCH_BIT];
    assign color_patched_o = color_read_control_q[RC_PATCH_BIT];
    assign color_subpatched_o = color_read_control_q[RC_SUBPATCH_BIT];

    // bytes per pixel from size bit
    assign color_bytes_log2 = color_format_q[CF_PIX32_BIT] ? 2'd2 : 2'd1;

    bacp_addr_gen u_depth_addr
    (
        .core_clk_i(core_clk_i),
        .arst_n_i(arst_n_i),
        .valid_i(pix_valid_i),
        .x_i(pix_x_i),
        .y_i(pix_y_i),
        .term_a_i(depth_read_control_q[RC_TERM_A_LSB +: PP_W]),
        .term_b_i(depth_read_control_q[RC_TERM_B_LSB +: PP_W]),
        .term_c_i(depth_read_control_q[RC_TERM_C_LSB +: PP_W]),
        .origin_select_i(depth_read_control_q[RC_ORIGIN_BIT]),
        .window_base_i(depth_window_base_q),
        .copy_offset_i(depth_copy_offset_q),
        .pixel_shift_i('0),
        .bytes_log2_i(2'd1),
        .dst_addr_o(depth_dst_addr_o),
        .src_addr_o(depth_src_addr_o)
    );

    bacp_addr_gen u_color_addr
    (
        .core_clk_i(core_clk_i),
        .arst_n_i(arst_n_i),
        .valid_i(pix_valid_i),
        .x_i(pix_x_i),
        .y_i(pix_y_i),
        .term_a_i(color_read_control_q[RC_TERM_A_LSB +: PP_W]),
        .term_b_i(color_read_control_q[RC_TERM_B_LSB +: PP_W]),
        .term_c_i(color_read_control_q[RC_TERM_C_LSB +: PP_W]),
        .origin_select_i(color_read_control_q[RC_ORIGIN_BIT]),
        .window_base_i(color_window_base_q),
        .copy_offset_i(color_copy_offset_q),
        .pixel_shift_i(color_pixel_shift_q),
        .bytes_log2_i(color_bytes_log2),
        .dst_addr_o(color_dst_addr_o),
        .src_addr_o(color_src_addr_o)
    );

    bacp_color_pack u_pack
    (
        .core_clk_i(core_clk_i),
        .arst_n_i(arst_n_i),
        .valid_i(pix_valid_i),
        .color_i(pix_color_i),
        .format_i(color_format_q[CF_FMT_LSB +: CF_FMT_W]),
        .channel_order_bit_i(color_format_q[CF_ORDER_BIT]),
        .pix32_i(color_format_q[CF_PIX32_BIT]),
        .raw_i(color_format_q[CF_RAW_BIT]),
        .word_o(color_word_o),
        .byte_en_o(color_byte_en_o),
        .format_bad_o(format_bad)
    );

    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            out_valid_o <= 1'b0;
            depth_word_o <= '0;
        end
        else
        begin
            out_valid_o <= pix_valid_i;
            if (pix_valid_i)
            begin
                if (depth_layout_q[DL_STENCIL_BIT])
                begin
                    depth_word_o <= {pix_stencil_i, pix_depth_i[14:0]};
                end
                else if (depth_layout_q[DL_DEPTH16_BIT])
                begin
                    depth_word_o <= pix_depth_i;
                end
                else
                begin
                    depth_word_o <= {1'b0, pix_depth_i[14:0]};
                end
            end
        end
    end
endmodule : bacp_top
`default_nettype wire

// ### testbench/bacp_top_chk.sv
// port-level assertions for the buffer address and color packer
`timescale 1ns/1ps
`default_nettype none
module bacp_top_chk
(
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic pix_valid_i,
    input wire logic [11:0] pix_x_i,
    input wire logic [11:0] pix_y_i,
    input wire logic [15:0] pix_depth_i,
    input wire logic out_valid_o,
    input wire logic [25:0] depth_dst_addr_o,
    input wire logic [25:0] depth_src_addr_o,
    input wire logic [15:0] depth_word_o,
    input wire logic [25:0] color_dst_addr_o,
    input wire logic [31:0] color_word_o,
    input wire logic [3:0] color_byte_en_o,
    input wire logic depth_patched_o
);
    wire logic apb_wr = psel_i & penable_i & pwrite_i;
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!arst_n_i);
    property p_ready;
        psel_i && penable_i |-> pready_o;
    endproperty
    a_ready: assert property (p_ready)
        else $error("access phase without ready");
    property p_err;
        psel_i && penable_i && paddr_i[1:0] == 2'b00 |-> pslverr_o == (paddr_i > 8'h24);
    endproperty
    a_err: assert property (p_err)
        else $error("error response wrong for address");
    property p_valid;
        pix_valid_i |=> out_valid_o;
    endproperty
    a_valid: assert property (p_valid)
        else $error("pixel result not one cycle later");
    property p_hold;
        !pix_valid_i |=> !out_valid_o && $stable(depth_dst_addr_o) && $stable(color_word_o);
    endproperty
    a_hold: assert property (p_hold)
        else $error("outputs moved without a pixel");
    property p_depth_even;
        out_valid_o |-> !depth_dst_addr_o[0] && !depth_src_addr_o[0];
    endproperty
    a_depth_even: assert property (p_depth_even)
        else $error("depth byte address odd");
    property p_color_even;
        out_valid_o |-> !color_dst_addr_o[0] && (color_byte_en_o inside {4'h3, 4'hf});
    endproperty
    a_color_even: assert property (p_color_even)
        else $error("color address or byte enables wrong");
    property p_depth_low;
        pix_valid_i |=> depth_word_o[14:0] == $past(pix_depth_i[14:0]);
    endproperty
    a_depth_low: assert property (p_depth_low)
        else $error("depth field not at bit zero");
    property p_step;
        pix_valid_i && $past(pix_valid_i) && !$past(apb_wr) && pix_y_i == $past(pix_y_i)
            && pix_x_i == $past(pix_x_i) + 1'b1
            |=> depth_dst_addr_o == $past(depth_dst_addr_o) + 26'h2;
    endproperty
    a_step: assert property (p_step)
        else $error("next pixel not two bytes on");
    property p_copy;
        out_valid_o && $past(out_valid_o) && !$past(apb_wr, 2)
            |-> depth_src_addr_o - depth_dst_addr_o
                == $past(depth_src_addr_o) - $past(depth_dst_addr_o);
    endproperty
    a_copy: assert property (p_copy)
        else $error("copy distance changed");
    property p_patch;
        !apb_wr |=> $stable(depth_patched_o);
    endproperty
    a_patch: assert property (p_patch)
        else $error("patch flag changed without write");
endmodule : bacp_top_chk
bind bacp_top bacp_top_chk i_chk (.core_clk_i, .arst_n_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pready_o, .pslverr_o, .pix_valid_i, .pix_x_i, .pix_y_i, .pix_depth_i,
    .out_valid_o, .depth_dst_addr_o, .depth_src_addr_o, .depth_word_o, .color_dst_addr_o,
    .color_word_o, .color_byte_en_o, .depth_patched_o);
`default_nettype wire

// ### testbench/bacp_sgram_model.sv
// behavioural graphics ram taking the packer's depth and color writes
`timescale 1ns/1ps
`default_nettype none
module bacp_sgram_model
(
    input wire logic core_clk_i,
    input wire logic wr_i,
    input wire logic [25:0] depth_addr_i,
    input wire logic [15:0] depth_word_i,
    input wire logic [25:0] color_addr_i,
    input wire logic [31:0] color_word_i,
    input wire logic [3:0] byte_en_i
);
    logic [7:0] mem [int];
    // unwritten bytes read as a fill pattern, never as a lucky match
    function automatic logic [7:0] rd(input int a);
        return mem.exists(a) ? mem[a] : 8'ha5;
    endfunction : rd
    always @(posedge core_clk_i)
    begin
        if (wr_i)
        begin
            mem[int'(depth_addr_i)] = depth_word_i[7:0];
            mem[int'(depth_addr_i) + 1] = depth_word_i[15:8];
            for (int i = 0; i < 4; i++)
            begin
                if (byte_en_i[i])
                begin
                    mem[int'(color_addr_i) + i] = color_word_i[8*i +: 8];
                end
            end
        end
    end
endmodule : bacp_sgram_model
`default_nettype wire

// ### testbench/testbench.sv
// self-checking bench for the buffer address and color packer
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) \
    begin \
        num_checks++; \
        if ((a) !== (b)) \
        begin \
            failures++; \
            $display("MISMATCH at %0t: got %h expected %h", $time, (a), (b)); \
        end \
    end
module testbench;
    import bacp_pkg::*;
    logic clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, color = 32'h0, cword;
    logic pready, pslverr, pv = 1'b0, stencil = 1'b0, ov, dpat, cpat, csub;
    logic [11:0] px = 12'h000, py = 12'h000;
    logic [15:0] depth = 16'h0, dword;
    logic [25:0] ddst, dsrc, cdst, csrc;
    logic [3:0] ben;
    int failures = 0, num_checks = 0;
    bacp_top i_dut
    (
        .core_clk_i(clk), .arst_n_i(arst_n), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .pix_valid_i(pv), .pix_x_i(px),
        .pix_y_i(py), .pix_color_i(color), .pix_depth_i(depth), .pix_stencil_i(stencil),
        .out_valid_o(ov), .depth_dst_addr_o(ddst), .depth_src_addr_o(dsrc),
        .depth_word_o(dword), .color_dst_addr_o(cdst), .color_src_addr_o(csrc),
        .color_word_o(cword), .color_byte_en_o(ben), .depth_patched_o(dpat),
        .color_patched_o(cpat), .color_subpatched_o(csub)
    );
    bacp_sgram_model i_mem
    (
        .core_clk_i(clk), .wr_i(ov), .depth_addr_i(ddst), .depth_word_i(dword),
        .color_addr_i(cdst), .color_word_i(cword), .byte_en_i(ben)
    );
    initial
    begin
        forever #2.5 clk = ~clk;
    end
    task automatic conclude();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
        begin
            $display("Test passed");
        end
        else
        begin
            $display("Test failed");
        end
        $finish;
    endtask : conclude
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            failures++;
            conclude();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
        `CHK(e, 1'b0)
    endtask : wr
    task automatic pixel(input logic [11:0] x, input logic [11:0] y, input logic [31:0] c,
        input logic [15:0] d, input logic s);
        @(posedge clk);
        pv <= 1'b1;
        px <= x;
        py <= y;
        color <= c;
        depth <= d;
        stencil <= s;
        @(posedge clk);
        pv <= 1'b0;
        #1;
        `CHK(ov, 1'b1)
    endtask : pixel
    task automatic s_reset();
        logic [31:0] r;
        logic e;
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        #1;
        `CHK(ov, 1'b0)
        apb(1'b0, REG_DEPTH_READ_CONTROL, 32'h0, r, e);
        `CHK(r, RESET_READ_CONTROL)
        apb(1'b0, REG_DEPTH_LAYOUT, 32'h0, r, e);
        `CHK(r, RESET_DEPTH_LAYOUT)
        apb(1'b1, 8'h40, 32'hffff_ffff, r, e);
        `CHK(e, 1'b1)
        apb(1'b0, 8'h40, 32'h0, r, e);
        `CHK(({e, r}), ({1'b1, 32'h0}))
    endtask : s_reset
    // depth width 16+64+512, color width 32+0+128
    // only supported widths are programmed
    task automatic s_addr(input logic o);
        logic [23:0] dp, cp;
        logic [31:0] r;
        logic e;
        dp = o ? 24'h001000 + 24'd1776 + 24'd5 : 24'h001000 - 24'd1776 + 24'd5;
        cp = (o ? 24'h002000 - 24'd480 : 24'h002000 + 24'd480) + 24'd5 + 24'h000300;
        wr(REG_DEPTH_READ_CONTROL, {20'h0, 1'b0, o, o, 9'h199});
        wr(REG_DEPTH_WINDOW_BASE, 32'h0000_1000);
        wr(REG_DEPTH_COPY_OFFSET, 32'h0000_0020);
        // color origin opposite to depth, so a shared select would show
        wr(REG_COLOR_READ_CONTROL, {20'h0, o, o, ~o, 9'h102});
        wr(REG_COLOR_WINDOW_BASE, 32'h0000_2000);
        wr(REG_COLOR_COPY_OFFSET, 32'h0000_0040);
        wr(REG_COLOR_PIXEL_SHIFT, 32'h0000_0300);
        wr(REG_COLOR_FORMAT, {25'h0, o, 6'h00});
        apb(1'b0, REG_DEPTH_READ_CONTROL, 32'h0, r, e);
        `CHK(r, ({20'h0, 1'b0, o, o, 9'h199}))
        pixel(12'd5, 12'd3, 32'h9c5ac3f1, 16'h1234, 1'b0);
        `CHK(ddst, ({1'b0, dp, 1'b0}))
        `CHK(dsrc, ({1'b0, dp + 24'h000020, 1'b0}))
        `CHK(cdst, (o ? {cp, 2'b00} : {1'b0, cp, 1'b0}))
        cp = cp + 24'h000040;
        `CHK(csrc, (o ? {cp, 2'b00} : {1'b0, cp, 1'b0}))
        `CHK(({dpat, cpat, csub}), ({o, o, o}))
        `CHK(ben, (o ? 4'hf : 4'h3))
        @(posedge clk);
        #1;
        `CHK(i_mem.rd(int'(cdst) + 2), (o ? 8'h5a : 8'ha5))
    endtask : s_addr
    task automatic s_depth_word();
        logic [1:0] lay [3] = '{2'd1, 2'd0, 2'd2};
        logic [15:0] e1 [3] = '{16'h36d3, 16'h36d3, 16'hb6d3};
        logic [15:0] e0 [3] = '{16'hb6d3, 16'h36d3, 16'h36d3};
        for (int i = 0; i < 3; i++)
        begin
            wr(REG_DEPTH_LAYOUT, {30'h0, lay[i]});
            pixel(12'd1, 12'd1, 32'h0, 16'h36d3, 1'b1);
            `CHK(dword, e1[i])
            pixel(12'd2, 12'd1, 32'h0, 16'hb6d3, 1'b0);
            `CHK(dword, e0[i])
        end
        wr(REG_DEPTH_LAYOUT, RESET_DEPTH_LAYOUT);
    endtask : s_depth_word
    task automatic s_formats();
        logic [4:0] f [17] = '{FMT_8888, FMT_5551_F, FMT_5551_B, FMT_4444, FMT_332_F,
            FMT_332_B, FMT_2321_F, FMT_2321_B, FMT_232_FO, FMT_232_BO, FMT_CI8, FMT_565_F,
            FMT_565_B, FMT_8888, FMT_565_F, FMT_CI8, 5'h12};
        // mode bits are raw, pixel size 32, order
        logic [2:0] m [17] = '{13: 3'h3, 14: 3'h1, 15: 3'h4, default: 3'h0};
        logic [31:0] x [17] = '{32'h9c5ac3f1, 32'haf1eaf1e, 32'haf1eaf1e, 32'h95cf95cf,
            32'h77777777, 32'h77777777, 32'hbbbbbbbb, 32'hbbbbbbbb, 32'h7b7b7b7b,
            32'h7b7b7b7b, 32'hf1f1f1f1, 32'h5e1e5e1e, 32'h5e1e5e1e, 32'h9cf1c35a,
            32'hf60bf60b, 32'h9c5ac3f1, 32'h00000000};
        logic [31:0] r;
        logic e;
        for (int i = 0; i < 17; i++)
        begin
            wr(REG_COLOR_FORMAT, {24'h0, m[i], f[i]});
            pixel(12'd7, 12'd2, 32'h9c5ac3f1, 16'h0, 1'b0);
            `CHK(cword, x[i])
            `CHK(ben, ((m[i][2] | m[i][1]) ? 4'hf : 4'h3))
        end
        apb(1'b0, REG_STATUS, 32'h0, r, e);
        `CHK(r[0], 1'b1)
        wr(REG_STATUS, 32'h1);
        apb(1'b0, REG_STATUS, 32'h0, r, e);
        `CHK(r[0], 1'b0)
    endtask : s_formats
    task automatic s_burst();
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk);
            pv <= 1'b1;
            px <= 12'(10 + i);
            py <= 12'd3;
        end
        @(posedge clk);
        pv <= 1'b0;
        #1;
        `CHK(ddst, ({1'b0, 24'h001000 + 24'd1776 + 24'd13, 1'b0}))
        repeat (3) @(posedge clk);
        #1;
        `CHK(ddst, ({1'b0, 24'h001000 + 24'd1776 + 24'd13, 1'b0}))
    endtask : s_burst
    initial
    begin
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        s_reset();
        s_addr(1'b0);
        s_addr(1'b1);
        s_depth_word();
        s_formats();
        s_burst();
        s_reset();
        conclude();
    end
endmodule : testbench
`default_nettype wire
